// [sfb_loader.sv]
`include "sfb_regs.svh"
module sfb_loader #(
  parameter int BOOT_CYC = `SFB_BOOT_MS * `SFB_CYC_PER_MS,
  parameter int IDLE_CYC = `SFB_IDLE_MS * `SFB_CYC_PER_MS,
  parameter int BIT_CYC = `SFB_BIT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic rxd,
  input wire logic host_rts,
  input wire logic unlock_sw,
  input wire logic [31:0] eeprom_interval,
  output logic txd,
  output logic mcu_cts,
  output logic pm_we,
  output logic [15:0] pm_addr,
  output logic [7:0] pm_wdata,
  output logic mcu_reset,
  output logic boot_active,
  output logic interval_load,
  output logic [31:0] ram_interval
);
  import sfb_pkg::*;
  sfb_uart_if u ();
  logic [1:0] rxd_s_q;
  logic [1:0] rts_s_q;
  logic [1:0] unl_s_q;
  sfb_state_t state_q;
  logic [31:0] tmr_q;
  logic nib_hi_q;
  logic [3:0] nib_q;
  logic [7:0] bcnt_q;
  logic [7:0] sum_q;
  logic [7:0] len_q;
  logic [15:0] addr_q;
  logic [7:0] type_q;
  logic [7:0] buf_q [0:255];
  logic [7:0] widx_q;
  logic [2:0] tx_idx_q;
  sfb_msg_t msg_q;
  logic tx_fire;
  logic [7:0] ch;
  logic hexv;
  logic [3:0] hexn;
  logic [7:0] byte_val;
  logic [7:0] dlen;
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rxd_s_q <= 2'h3;
      rts_s_q <= 2'h0;
      unl_s_q <= 2'h0;
    end else begin
      rxd_s_q <= {rxd_s_q[0], rxd};
      rts_s_q <= {rts_s_q[0], host_rts};
      unl_s_q <= {unl_s_q[0], unlock_sw};
    end
  end
  sfb_uart #(.BIT_CYC(BIT_CYC)) u_sfb_uart (
    .clk(clk),
    .srst(srst),
    .rxd_sync(rxd_s_q[1]),
    .cts_sync(rts_s_q[1]),
    .txd_q(txd),
    .u(u)
  );
  // ----------------------------------------
  // Character decode
  // ----------------------------------------
  assign ch = u.rx_data;
  always_comb begin
    hexv = 1'b1;
    hexn = 4'h0;
    if (ch >= 8'h30 && ch <= 8'h39) begin
      hexn = 4'(ch - 8'h30);
    end else if (ch >= 8'h41 && ch <= 8'h46) begin
      hexn = 4'(ch - 8'h37);
    end else if (ch >= 8'h61 && ch <= 8'h66) begin
      hexn = 4'(ch - 8'h57);
    end else begin
      hexv = 1'b0;
    end
  end
  assign byte_val = {nib_q, hexn};
  // Header is 4 bytes, trailer 1 checksum byte
  assign dlen = bcnt_q - 8'h04;
  // ----------------------------------------
  // Loader sequence
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= SFB_BOOT;
      tmr_q <= 32'h0;
      nib_hi_q <= 1'b1;
      nib_q <= 4'h0;
      bcnt_q <= 8'h00;
      sum_q <= 8'h00;
      len_q <= 8'h00;
      addr_q <= 16'h0000;
      type_q <= 8'h00;
      widx_q <= 8'h00;
      msg_q <= SFB_MSG_NONE;
    end else begin
      unique case (state_q)
        SFB_BOOT: begin
          tmr_q <= tmr_q + 32'h1;
          if (tmr_q >= 32'(BOOT_CYC - 1)) begin // R3
            state_q <= SFB_WAIT;
            tmr_q <= 32'h0;
          end
        end
        SFB_WAIT, SFB_HEX: begin // R13
          tmr_q <= tmr_q + 32'h1;
          if (u.rx_valid) begin
            tmr_q <= 32'h0;
            if (ch == `SFB_CH_COLON) begin // R4
              state_q <= SFB_HEX;
              nib_hi_q <= 1'b1;
              bcnt_q <= 8'h00;
              sum_q <= 8'h00;
            end else if (ch == `SFB_CH_DISARM && state_q == SFB_WAIT) begin
              msg_q <= SFB_MSG_DISARM;
              state_q <= SFB_REPLY;
            end else if (state_q == SFB_HEX && hexv) begin
              nib_hi_q <= ~nib_hi_q;
              nib_q <= hexn;
              if (!nib_hi_q) begin
                sum_q <= sum_q + byte_val;
                bcnt_q <= bcnt_q + 8'h01;
                unique case (bcnt_q)
                  8'h00: len_q <= byte_val;
                  8'h01: addr_q[15:8] <= byte_val;
                  8'h02: addr_q[7:0] <= byte_val;
                  8'h03: type_q <= byte_val;
                  default: buf_q[dlen] <= byte_val;
                endcase
              end
            end else if (state_q == SFB_HEX) begin
              state_q <= SFB_CHECK; // CR, LF or other ends record
            end
          end else if (tmr_q >= 32'(IDLE_CYC - 1)) begin
            state_q <= SFB_APP; // R8
          end
        end
        SFB_CHECK: begin
          // R14
          if (sum_q == 8'h00 && bcnt_q == len_q + 8'h05 && nib_hi_q && unl_s_q[1]) begin
            widx_q <= 8'h00;
            state_q <= (type_q == `SFB_REC_DATA && len_q != 8'h00) ? SFB_WRITE : SFB_REPLY;
            msg_q <= SFB_MSG_OK;
          end else begin
            state_q <= SFB_WAIT; // R14
          end
          tmr_q <= 32'h0;
        end
        SFB_WRITE: begin
          widx_q <= widx_q + 8'h01; // R7
          if (widx_q == len_q - 8'h01) begin
            state_q <= SFB_REPLY;
          end
        end
        SFB_REPLY: begin
          tmr_q <= 32'h0;
          if (tx_fire && tx_idx_q == 3'h4) begin
            state_q <= SFB_WAIT; // R5
          end
        end
        SFB_APP: begin
          state_q <= SFB_APP;
        end
        default: state_q <= SFB_BOOT;
      endcase
    end
  end
  // ----------------------------------------
  // Reply text: "Ok\r\n" or "zxdU\r\n"/"zxdL\r\n" (trimmed to 5 chars)
  // ----------------------------------------
  always_comb begin
    u.tx_data = `SFB_CH_LF;
    unique case (tx_idx_q)
      3'h0: u.tx_data = (msg_q == SFB_MSG_OK) ? `SFB_CH_O : `SFB_CH_X;
      3'h1: u.tx_data = (msg_q == SFB_MSG_OK) ? `SFB_CH_K : `SFB_CH_D;
      3'h2: u.tx_data = (msg_q == SFB_MSG_OK) ? `SFB_CH_CR :
                        (unl_s_q[1] ? `SFB_CH_U : `SFB_CH_L); // R9
      3'h3: u.tx_data = (msg_q == SFB_MSG_OK) ? `SFB_CH_LF : `SFB_CH_CR;
      default: u.tx_data = `SFB_CH_LF;
    endcase
  end
  assign u.tx_valid = (state_q == SFB_REPLY) &&
                      !(msg_q == SFB_MSG_OK && tx_idx_q == 3'h4);
  assign tx_fire = (state_q == SFB_REPLY) &&
                   ((u.tx_valid && u.tx_ready) || (msg_q == SFB_MSG_OK && tx_idx_q == 3'h4));
  always_ff @(posedge clk) begin
    if (srst || state_q != SFB_REPLY) begin
      tx_idx_q <= 3'h0;
    end else if (tx_fire) begin
      tx_idx_q <= tx_idx_q + 3'h1; // R5
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pm_we <= 1'b0;
      pm_addr <= 16'h0000;
      pm_wdata <= 8'h00;
      mcu_reset <= 1'b1;
      boot_active <= 1'b0;
      mcu_cts <= 1'b0;
      interval_load <= 1'b0;
      ram_interval <= 32'h0;
    end else begin
      pm_we <= (state_q == SFB_WRITE); // R7
      pm_addr <= addr_q + {8'h00, widx_q};
      pm_wdata <= buf_q[widx_q];
      mcu_reset <= (state_q != SFB_APP); // R8
      boot_active <= (state_q != SFB_BOOT) && (state_q != SFB_APP); // R3
      mcu_cts <= (state_q == SFB_WAIT) || (state_q == SFB_HEX); // R1
      interval_load <= 1'b0;
      // Reload on loader entry and again on the restart into the application
      if ((state_q == SFB_BOOT && tmr_q == 32'h0) || (state_q == SFB_APP && mcu_reset)) begin
        interval_load <= 1'b1; // R12
        ram_interval <= eeprom_interval; // R12
      end
    end
  end
endmodule : sfb_loader

// [sfb_regs.svh]
`ifndef SFB_REGS_SVH
`define SFB_REGS_SVH
// Summary of operation
// R1 - UART 115200 baud with CTS/RTS handshaking
// R2 - Host sends 0x19 to reset device; the loader never treats 0x19 as a reset, only srst resets it
// R3 - Bootloader enabled within seconds after reset
// R4 - Host sends record starting with colon
// R5 - Good record answered with Ok CR LF
// R6 - Host waits for acknowledge before next
// R7 - Record data overwrites program memory
// R8 - Silence for seconds makes device reset
// R9 - Disarm reply ends U when unlocked
// R10 - Host checks unlock switch before loading
// R11 - Host zeroes RAM interval before loading
// R12 - After load, EEPROM interval copied to RAM
// R13 - No reply to non-meter requests; timeout
// R14 - Bad checksum record: no acknowledge, no write
`define SFB_CLK_HZ 250000000
`define SFB_BAUD 115200
`define SFB_BIT_CYC (`SFB_CLK_HZ / `SFB_BAUD)
`define SFB_HALF_CYC (`SFB_BIT_CYC / 2)
`define SFB_BOOT_MS 2000
`define SFB_IDLE_MS 3000
`define SFB_CYC_PER_MS 250000
`define SFB_CH_RESET 8'h19
`define SFB_CH_COLON 8'h3a
`define SFB_CH_DISARM 8'h7a
`define SFB_CH_O 8'h4f
`define SFB_CH_K 8'h6b
`define SFB_CH_CR 8'h0d
`define SFB_CH_LF 8'h0a
`define SFB_CH_U 8'h55
`define SFB_CH_L 8'h4c
`define SFB_CH_X 8'h78
`define SFB_CH_D 8'h64
`define SFB_REC_DATA 8'h00
`endif

// [sfb_pkg.sv]
package sfb_pkg;
  typedef enum logic [6:0] {
    SFB_BOOT = 7'h01,
    SFB_WAIT = 7'h02,
    SFB_HEX = 7'h04,
    SFB_CHECK = 7'h08,
    SFB_WRITE = 7'h10,
    SFB_REPLY = 7'h20,
    SFB_APP = 7'h40
  } sfb_state_t;
  typedef enum logic [1:0] {
    SFB_MSG_OK = 2'h0,
    SFB_MSG_DISARM = 2'h1,
    SFB_MSG_NONE = 2'h2
  } sfb_msg_t;
endpackage : sfb_pkg

// [sfb_uart_if.sv]
interface sfb_uart_if;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  modport core (input rx_data, input rx_valid, output tx_data, output tx_valid,
    input tx_ready);
  modport phy (output rx_data, output rx_valid, input tx_data, input tx_valid,
    output tx_ready);
endinterface : sfb_uart_if

// [sfb_uart.sv]
`include "sfb_regs.svh"
module sfb_uart #(
  parameter int BIT_CYC = `SFB_BIT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic rxd_sync,
  input wire logic cts_sync,
  output logic txd_q,
  sfb_uart_if.phy u
);
  import sfb_pkg::*;
  logic [11:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_busy_q;
  logic [11:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;
  logic rx_valid_q;
  // ----------------------------------------
  // Receiver, 8N1, sampled mid-bit
  // ----------------------------------------
  always_ff @(posedge clk) begin
    rx_valid_q <= 1'b0;
    if (srst) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 12'h000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
    end else if (!rx_busy_q) begin
      if (!rxd_sync) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q <= 12'(BIT_CYC / 2);
        rx_bit_q <= 4'h0;
      end
    end else if (rx_cnt_q != 12'h000) begin
      rx_cnt_q <= rx_cnt_q - 12'h001;
    end else begin
      rx_cnt_q <= 12'(BIT_CYC - 1); // R1
      // Stop bit is checked, not kept, so the data byte lands aligned
      if (rx_bit_q != 4'h9) begin
        rx_sh_q <= {rxd_sync, rx_sh_q[7:1]};
      end
      rx_bit_q <= rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0 && rxd_sync) begin
        rx_busy_q <= 1'b0;
      end else if (rx_bit_q == 4'h9) begin
        rx_busy_q <= 1'b0;
        rx_valid_q <= rxd_sync;
      end
    end
  end
  assign u.rx_data = rx_sh_q;
  assign u.rx_valid = rx_valid_q;
  // ----------------------------------------
  // Transmitter, starts a byte only while host asserts its ready
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_bit_q <= 4'h0;
      tx_cnt_q <= 12'h000;
      tx_sh_q <= 10'h3ff;
      txd_q <= 1'b1;
    end else if (tx_bit_q == 4'h0) begin
      txd_q <= 1'b1;
      if (u.tx_valid && cts_sync) begin // R1
        tx_sh_q <= {1'b1, u.tx_data, 1'b0};
        // One spare step so the stop bit runs a full bit time
        tx_bit_q <= 4'hb;
        tx_cnt_q <= 12'h000;
      end
    end else if (tx_cnt_q != 12'h000) begin
      tx_cnt_q <= tx_cnt_q - 12'h001;
    end else begin
      txd_q <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_cnt_q <= 12'(BIT_CYC - 1); // R1
      tx_bit_q <= tx_bit_q - 4'h1;
    end
  end
  assign u.tx_ready = (tx_bit_q == 4'h0) && cts_sync;
endmodule : sfb_uart

// [sfb_loader_props.sv]
module sfb_loader_props #(
  parameter int BOOT_CYC = 100,
  parameter int BIT_CYC = 2170
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic txd,
  input wire logic mcu_cts,
  input wire logic pm_we,
  input wire logic [15:0] pm_addr,
  input wire logic mcu_reset,
  input wire logic boot_active,
  input wire logic interval_load,
  input wire logic [31:0] eeprom_interval,
  input wire logic [31:0] ram_interval
);
  localparam int BOOT_MAX = BOOT_CYC + 16;
  localparam int BIT_MIN = BIT_CYC - 2;
  logic txd_q;
  logic [11:0] run_q;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ------
  // Length of each txd level; a clipped bit shows as a short run
  // ------
  always_ff @(posedge clk) begin
    txd_q <= txd;
    if (srst || txd != txd_q) run_q <= 12'h000;
    else if (run_q != 12'hfff) run_q <= run_q + 12'h001;
  end
  AST_BOOT_READY: assert property ($fell(srst) |-> ##[1:BOOT_MAX] mcu_cts)
    else $error("loader did not open in time");
  AST_APP_HELD: assert property (boot_active |-> mcu_reset)
    else $error("application runs while loader active");
  AST_CTS_IN_BOOT: assert property (mcu_cts |-> boot_active)
    else $error("bytes accepted outside loader");
  AST_LOAD_PULSE: assert property ($fell(srst) |-> ##[0:2] interval_load ##1 !interval_load)
    else $error("interval reload pulse missing");
  AST_RAM_COPY: assert property ($fell(interval_load) |-> ram_interval == eeprom_interval)
    else $error("ram interval not reloaded");
  AST_WRITE_IN_BOOT: assert property (pm_we |-> mcu_reset && !mcu_cts)
    else $error("write outside record processing");
  AST_ADDR_STEP: assert property (pm_we && $past(pm_we) |-> pm_addr == $past(pm_addr) + 16'h0001)
    else $error("write address not consecutive");
  AST_BIT_TIME: assert property (txd != txd_q |-> run_q >= 12'(BIT_MIN))
    else $error("txd bit too short");
  AST_SELF_RESTART: assert property ($fell(mcu_reset) |-> !boot_active && !mcu_cts)
    else $error("restart with loader still open");
  cover property (pm_we ##1 pm_we);
  cover property ($fell(mcu_reset));
  cover property ($fell(txd));
endmodule : sfb_loader_props

bind sfb_loader sfb_loader_props #(.BOOT_CYC(BOOT_CYC), .BIT_CYC(BIT_CYC)) u_sfb_loader_props (
  .clk(clk), .srst(srst), .txd(txd), .mcu_cts(mcu_cts), .pm_we(pm_we), .pm_addr(pm_addr),
  .mcu_reset(mcu_reset), .boot_active(boot_active), .interval_load(interval_load),
  .eeprom_interval(eeprom_interval), .ram_interval(ram_interval));

// [sfb_host_model.sv]
module sfb_host_model #(
  parameter int BIT_CYC = 2170
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic host_rts
);
  timeunit 1ns;
  timeprecision 100ps;
  int rts_err = 0;
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;
  // ------
  // Adaptor side of the serial link, 8N1, idle high
  // ------
  initial begin
    rxd = 1'b1;
    host_rts = 1'b1;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) #1 rxd = f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    #1;
  endtask : send
  // RTS drops after each byte so the loader must pace itself
  always begin
    @(negedge txd);
    if (host_rts !== 1'b1) rts_err++;
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      rx_b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    rx_q.push_back(rx_b);
    #1 host_rts = 1'b0;
    repeat (BIT_CYC * 2) @(posedge clk);
    #1 host_rts = 1'b1;
  end
endmodule : sfb_host_model

// [tb_serial_firmware_bootloader.sv]
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp); end end

module tb_serial_firmware_bootloader;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, srst, rxd, host_rts, unlock_sw, txd, mcu_cts, pm_we;
  logic mcu_reset, boot_active, interval_load;
  logic [15:0] pm_addr;
  logic [7:0] pm_wdata;
  logic [31:0] eeprom_interval, ram_interval;
  logic [23:0] wq[$];
  int failures, compares;
  // ------
  // Loader with short boot, idle and bit counts to keep the run short
  // ------
  sfb_loader #(.BOOT_CYC(100), .IDLE_CYC(4000), .BIT_CYC(32)) u_sfb_loader (.clk(clk),
    .srst(srst),
    .rxd(rxd), .host_rts(host_rts), .unlock_sw(unlock_sw), .eeprom_interval(eeprom_interval),
    .txd(txd), .mcu_cts(mcu_cts), .pm_we(pm_we), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
    .mcu_reset(mcu_reset), .boot_active(boot_active), .interval_load(interval_load),
    .ram_interval(ram_interval));
  sfb_host_model #(.BIT_CYC(32)) u_sfb_host_model (.clk(clk), .txd(txd), .rxd(rxd),
    .host_rts(host_rts));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (pm_we === 1'b1) wq.push_back({pm_addr, pm_wdata});
  task automatic final_report();
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // Kinds: 0 CTS up, 1 n reply bytes held, 2 application released
  task automatic wait_on(input int w, input int n, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      if (w == 0 && mcu_cts === 1'b1) break;
      if (w == 1 && u_sfb_host_model.rx_q.size() >= n) break;
      if (w == 2 && mcu_reset === 1'b0) break;
      @(posedge clk) #1;
    end
    if (k == lim) begin
      failures++;
      final_report();
    end
  endtask : wait_on
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      wait_on(0, 0, 5000);
      u_sfb_host_model.send(s[i]);
    end
  endtask : send_str
  task automatic expect_reply(input string s);
    logic [7:0] b;
    wait_on(1, s.len(), 5000);
    for (int i = 0; i < s.len(); i++) begin
      b = u_sfb_host_model.rx_q.pop_front();
      `CHK(b, s[i])
    end
  endtask : expect_reply
  task automatic t_boot();
    wait_on(0, 0, 200);
    `CHK(mcu_reset, 1'b1)
    `CHK(boot_active, 1'b1)
    `CHK(ram_interval, eeprom_interval)
  endtask : t_boot
  task automatic t_good();
    send_str(":02001000A55AEF\015\012");
    expect_reply("Ok\015\012");
    `CHK(wq.size(), 2)
    `CHK(wq[0], 24'h0010a5)
    `CHK(wq[1], 24'h00115a)
    wq.delete();
  endtask : t_good
  task automatic t_bad();
    // Kept below the idle count so the loader stays open
    send_str(":02001000A55AEE\015\012");
    repeat (1200) @(posedge clk);
    `CHK(u_sfb_host_model.rx_q.size(), 0)
    `CHK(wq.size(), 0)
  endtask : t_bad
  task automatic t_disarm();
    for (int lk = 0; lk < 2; lk++) begin
      @(posedge clk) #1 unlock_sw = lk[0];
      send_str("z");
      expect_reply(lk ? "xdU\015\012" : "xdL\015\012");
    end
  endtask : t_disarm
  task automatic t_idle();
    eeprom_interval = 32'h00000258;
    wait_on(2, 0, 6000);
    `CHK(mcu_reset, 1'b0)
    `CHK(boot_active, 1'b0)
    `CHK(interval_load, 1'b1)
    `CHK(ram_interval, 32'h00000258)
    `CHK(u_sfb_host_model.rts_err, 0)
  endtask : t_idle
  initial begin
    failures = 0;
    compares = 0;
    srst = 1'b1;
    unlock_sw = 1'b1;
    eeprom_interval = 32'h00000e10;
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    t_boot();
    t_good();
    t_bad();
    t_disarm();
    t_idle();
    final_report();
  end
endmodule : tb_serial_firmware_bootloader
